/* File: design/eqs_consts.svh */
// timing, width and reset constants for the equalizer status pin block
`ifndef EQS_CONSTS_SVH
`define EQS_CONSTS_SVH

// clock rate in MHz
`define EQS_CLK_MHZ          125
// longest middle phase of a restart pulse on the polarity pin, in ns
`define EQS_PULSE_MAX_NS     10000
// longest time rounds down to whole cycles
`define EQS_PULSE_CYC        ((`EQS_PULSE_MAX_NS * `EQS_CLK_MHZ) / 1000)
// time the loop must stay converged before lock is reported, in us
`define EQS_SETTLE_US        100
`define EQS_SETTLE_CYC       (`EQS_SETTLE_US * `EQS_CLK_MHZ)
// counter width, covers both counts above
`define EQS_CNT_W            16
// number of pin inputs passed through synchronisers
`define EQS_NSYNC            5
// synchroniser lane positions
`define EQS_SY_COLOR         0
`define EQS_SY_POL           1
`define EQS_SY_FREEZE        2
`define EQS_SY_EQOFF         3
`define EQS_SY_ALONE         4
// reset levels
`define EQS_RST_BIT          1'h0
`define EQS_RST_CNT          16'h0000

`endif

/* File: design/eqs_pkg.sv */
// types shared by the equalizer status pin block
package eqs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQUIRE,
    ST_SETTLE,
    ST_EQ_SETTLED_FLAG
  } eqs_state_t;

  // results from the analog detectors, same clock domain
  typedef struct packed {
    logic signalPresent;
    logic burstSeen;
    logic invertSeen;
    logic eqConverged;
  } eqs_detect_t;

  // controls towards the analog equalizer and signal chain
  typedef struct packed {
    logic colorMode;
    logic invertChain;
    logic eqUpdateEn;
    logic eqBypass;
    logic acqRestart;
  } eqs_ctrl_t;

endpackage

/* File: design/eqs_status_pins.sv */
// status and override pin logic around the equalizer acquisition machine
//
// Behaviour
// - colorburst pin reports burst present, else 0
// - driven colorburst pin forces color/monochrome mode
// - weak outputs; outside drive overrides, becomes forcing
// - color indication may err beyond 4800 feet
// - polarity pin reports 0 nominal, 1 inverted
// - driven polarity pin sets signal chain inversion
// - stand-alone polarity pulse restarts signal acquisition
// - lock rises only when equalized, settled; freeze 1 holds it at 1 when convergence drops
// - lock may err on long monochrome runs
// - freeze 1 holds equalizer state, 0 updates
// - equalizer-off 1 disables equalization, 0 normal
`include "eqs_consts.svh"

module eqs_status_pins #(
  parameter int unsigned SETTLE_CYC = `EQS_SETTLE_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire eqs_pkg::eqs_detect_t detect,
  output eqs_pkg::eqs_ctrl_t       ctrl,
  input  wire logic                colorPinIn,
  output logic                     colorPinOut,
  output logic                     colorPinOe,
  input  wire logic                polPinIn,
  output logic                     polPinOut,
  output logic                     polPinOe,
  input  wire logic                freezeIn,
  input  wire logic                equalizer_off_input,
  input  wire logic                standAloneIn,
  output logic                     eq_settled_flag,
  output logic                     colorForced,
  output logic                     polForced
);

  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [`EQS_NSYNC-1:0] pinRaw;
  logic [`EQS_NSYNC-1:0] syncA_r;
  logic [`EQS_NSYNC-1:0] syncB_r;

  assign pinRaw = {standAloneIn, equalizer_off_input, freezeIn, polPinIn, colorPinIn};

  genvar g;
  generate
    for (g = 0; g < `EQS_NSYNC; g++)
    begin : gSync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          syncA_r[g] <= `EQS_RST_BIT;
          syncB_r[g] <= `EQS_RST_BIT;
        end
        else
        begin
          syncA_r[g] <= pinRaw[g];
          syncB_r[g] <= syncA_r[g];
        end
      end
    end
  endgenerate

  wire colorSync = syncB_r[`EQS_SY_COLOR];
  wire polSync   = syncB_r[`EQS_SY_POL];
  wire freezeOn  = syncB_r[`EQS_SY_FREEZE];
  wire eqOff     = syncB_r[`EQS_SY_EQOFF];
  wire alone     = syncB_r[`EQS_SY_ALONE];

  // ---------------------------------------------------------------
  // weak indicator drive
  // ---------------------------------------------------------------
  // the pins are only weakly driven, so the resolved level read back is
  // our own value unless someone outside drives harder; the read-back
  // level is therefore the forcing input in both cases
  logic colorOut_r;
  logic polOut_r;
  logic [1:0] colorDly_r;
  logic [2:0] polDly_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      colorOut_r <= `EQS_RST_BIT;
      polOut_r   <= `EQS_RST_BIT;
      colorDly_r <= '0;
      polDly_r   <= '0;
    end
    else
    begin
      // indications follow the detectors unqualified; on long monochrome
      // runs the burst detector may be wrong, equalization does not care
      colorOut_r <= detect.burstSeen;
      polOut_r   <= detect.invertSeen;
      colorDly_r <= {colorDly_r[0], colorOut_r};
      polDly_r   <= {polDly_r[1:0], polOut_r};
    end
  end

  assign colorPinOut = colorOut_r;
  assign polPinOut   = polOut_r;
  assign colorPinOe  = 1'h1;
  assign polPinOe    = 1'h1;

  // read-back differs from what we drove two cycles ago: outside drive
  function automatic logic isOverridden(input logic readBack, input logic driven);
    isOverridden = readBack != driven;
  endfunction

  wire colorOverNxt = isOverridden(colorSync, colorDly_r[1]);
  wire polOverNxt   = isOverridden(polSync, polDly_r[1]);

  // ---------------------------------------------------------------
  // restart pulse on the polarity pin
  // ---------------------------------------------------------------
  // edges that coincide with a change of our own drive are ignored, so
  // the detector flipping never looks like a restart pulse
  logic                 polPrev_r;
  logic                 pulseArmed_r;
  logic [`EQS_CNT_W-1:0] pulseCnt_r;

  wire polEdge    = polSync != polPrev_r;
  wire ownStable  = polDly_r[1] == polDly_r[2];
  wire extEdge    = polEdge && ownStable;
  wire pulseLate  = pulseCnt_r == `EQS_CNT_W'(`EQS_PULSE_CYC);
  wire restartReq = extEdge && pulseArmed_r && alone;
  wire armNxt     = extEdge ? !pulseArmed_r : (pulseArmed_r && !pulseLate);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      polPrev_r    <= `EQS_RST_BIT;
      pulseArmed_r <= `EQS_RST_BIT;
      pulseCnt_r   <= `EQS_RST_CNT;
    end
    else
    begin
      polPrev_r    <= polSync;
      pulseArmed_r <= armNxt;
      pulseCnt_r   <= extEdge ? `EQS_RST_CNT : pulseCnt_r + `EQS_CNT_W'(pulseArmed_r);
    end
  end

  // ---------------------------------------------------------------
  // acquisition state machine
  // ---------------------------------------------------------------
  eqs_pkg::eqs_state_t   state_r;
  eqs_pkg::eqs_state_t   state_nxt;
  logic [`EQS_CNT_W-1:0] settleCnt_r;

  wire settleDone = settleCnt_r == `EQS_CNT_W'(SETTLE_CYC - 1);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      eqs_pkg::ST_IDLE:
        if (detect.signalPresent)
          state_nxt = eqs_pkg::ST_ACQUIRE;
      eqs_pkg::ST_ACQUIRE:
        if (!detect.signalPresent)
          state_nxt = eqs_pkg::ST_IDLE;
        else if (detect.eqConverged)
          state_nxt = eqs_pkg::ST_SETTLE;
      eqs_pkg::ST_SETTLE:
        if (!detect.signalPresent)
          state_nxt = eqs_pkg::ST_IDLE;
        else if (!detect.eqConverged)
          state_nxt = eqs_pkg::ST_ACQUIRE;
        else if (settleDone)
          state_nxt = eqs_pkg::ST_EQ_SETTLED_FLAG;
      eqs_pkg::ST_EQ_SETTLED_FLAG:
        if (!detect.signalPresent)
          state_nxt = eqs_pkg::ST_IDLE;
        else if (!detect.eqConverged && !freezeOn)
          state_nxt = eqs_pkg::ST_ACQUIRE;
      default:
        state_nxt = eqs_pkg::ST_IDLE;
    endcase
    // a restart wins over the state logic (equalizer-off still wins over it) and clears lock,
    // which in turn lets go of a freeze input tied back to the lock flag
    if (restartReq)
      state_nxt = eqs_pkg::ST_ACQUIRE;
    if (eqOff)
      state_nxt = eqs_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= eqs_pkg::ST_IDLE;
      settleCnt_r <= `EQS_RST_CNT;
    end
    else
    begin
      state_r     <= state_nxt;
      settleCnt_r <= (state_nxt == eqs_pkg::ST_SETTLE && state_r == eqs_pkg::ST_SETTLE)
                     ? settleCnt_r + `EQS_CNT_W'(1) : `EQS_RST_CNT;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  eqs_pkg::eqs_ctrl_t ctrl_r;
  eqs_pkg::eqs_ctrl_t ctrl_nxt;
  logic               lock_r;
  logic               colorForced_r;
  logic               polForced_r;

  always_comb
  begin
    ctrl_nxt             = '0;
    ctrl_nxt.colorMode   = colorSync;
    ctrl_nxt.invertChain = polSync;
    ctrl_nxt.eqUpdateEn  = !freezeOn && !eqOff;
    ctrl_nxt.eqBypass    = eqOff;
    ctrl_nxt.acqRestart  = restartReq && !eqOff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r        <= '0;
      lock_r        <= `EQS_RST_BIT;
      colorForced_r <= `EQS_RST_BIT;
      polForced_r   <= `EQS_RST_BIT;
    end
    else
    begin
      ctrl_r        <= ctrl_nxt;
      // lock may misreport on long monochrome runs, like the burst flag
      lock_r        <= state_nxt == eqs_pkg::ST_EQ_SETTLED_FLAG;
      colorForced_r <= colorOverNxt;
      polForced_r   <= polOverNxt;
    end
  end

  assign ctrl            = ctrl_r;
  assign eq_settled_flag = lock_r;
  assign colorForced     = colorForced_r;
  assign polForced       = polForced_r;

endmodule

/* File: sim/eqs_status_pins_chk.sv */
// assertion checker for the equalizer status pin block
module eqs_status_pins_chk #(
  parameter int unsigned SETTLE_CYC = 20
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire eqs_pkg::eqs_detect_t detect,
  input wire eqs_pkg::eqs_ctrl_t   ctrl,
  input wire logic                 colorPinIn,
  input wire logic                 colorPinOut,
  input wire logic                 colorPinOe,
  input wire logic                 polPinIn,
  input wire logic                 polPinOut,
  input wire logic                 polPinOe,
  input wire logic                 freezeIn,
  input wire logic                 equalizer_off_input,
  input wire logic                 standAloneIn,
  input wire logic                 eq_settled_flag,
  input wire logic                 colorForced,
  input wire logic                 polForced
);
  timeunit 1ns;
  timeprecision 1ps;
  // run of converged cycles with signal present, lock may not rise before it is long enough
  logic [15:0] convRun_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      convRun_r <= 16'h0000;
    else if (detect.signalPresent && detect.eqConverged)
      convRun_r <= convRun_r + 16'h0001;
    else
      convRun_r <= 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_colorOut; $past(rst_n) |-> colorPinOut == $past(detect.burstSeen); endproperty
  a_colorOut: assert property (p_colorOut) else $error("color drive wrong");
  property p_polOut; $past(rst_n) |-> polPinOut == $past(detect.invertSeen); endproperty
  a_polOut: assert property (p_polOut) else $error("polarity drive wrong");
  property p_mode; $past(rst_n, 3) |-> ctrl.colorMode == $past(colorPinIn, 3); endproperty
  a_mode: assert property (p_mode) else $error("color mode wrong");
  property p_inv; $past(rst_n, 3) |-> ctrl.invertChain == $past(polPinIn, 3); endproperty
  a_inv: assert property (p_inv) else $error("chain inversion wrong");
  property p_oe; colorPinOe && polPinOe; endproperty
  a_oe: assert property (p_oe) else $error("weak drive off");
  property p_frz;
    $past(rst_n, 3) |-> ctrl.eqUpdateEn == (!$past(freezeIn, 3) && !$past(equalizer_off_input, 3));
  endproperty
  a_frz: assert property (p_frz) else $error("update enable wrong");
  property p_off;
    $past(rst_n, 4) && $past(equalizer_off_input, 4) && $past(equalizer_off_input, 3)
      |-> ctrl.eqBypass && !eq_settled_flag;
  endproperty
  a_off: assert property (p_off) else $error("disable not honoured");
  property p_rsLock; ctrl.acqRestart |-> !eq_settled_flag; endproperty
  a_rsLock: assert property (p_rsLock) else $error("lock kept on restart");
  property p_rsPulse; ctrl.acqRestart |=> !ctrl.acqRestart; endproperty
  a_rsPulse: assert property (p_rsPulse) else $error("restart too long");
  property p_lockSig; eq_settled_flag |-> $past(detect.signalPresent); endproperty
  a_lockSig: assert property (p_lockSig) else $error("lock without signal");
  property p_lockRise; $rose(eq_settled_flag) |-> convRun_r >= SETTLE_CYC; endproperty
  a_lockRise: assert property (p_lockRise) else $error("lock too early");
  c_lock: cover property ($rose(eq_settled_flag));
  c_restart: cover property (ctrl.acqRestart);
  c_forced: cover property (colorForced && polForced);
endmodule

/* File: sim/eqs_board_model.sv */
// board glue model: resolves the shared status pins and the freeze strap
module eqs_board_model (
  input  wire logic colorOut,
  input  wire logic colorOe,
  input  wire logic colorDrv,
  input  wire logic colorVal,
  input  wire logic polOut,
  input  wire logic polOe,
  input  wire logic polDrv,
  input  wire logic polVal,
  input  wire logic lockIn,
  input  wire logic lockToFreeze,
  input  wire logic freezeReq,
  output logic      colorPin,
  output logic      polPin,
  output logic      freezePin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a strong outside drive beats the weak on-chip one; an undriven pin reads low
  assign colorPin  = colorDrv ? colorVal : (colorOe & colorOut);
  assign polPin    = polDrv ? polVal : (polOe & polOut);
  assign freezePin = lockToFreeze ? lockIn : freezeReq;
endmodule

/* File: sim/tb.sv */
// self-checking bench for the equalizer status pin block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 20;
  logic rst_n, clk, colorDrv, colorVal, polDrv, polVal, lockToFreeze, freezeReq, eqOff, alone;
  logic colorPin, colorOut, colorOe, polPin, polOut, polOe, freezePin, lock, cForced, pForced;
  eqs_pkg::eqs_detect_t det;
  eqs_pkg::eqs_ctrl_t   ctrl;
  int mismatches, samplesChecked;
  eqs_status_pins #(.SETTLE_CYC(SETTLE)) dut (.clk(clk), .rst_n(rst_n), .detect(det),
    .ctrl(ctrl), .colorPinIn(colorPin), .colorPinOut(colorOut), .colorPinOe(colorOe),
    .polPinIn(polPin), .polPinOut(polOut), .polPinOe(polOe), .freezeIn(freezePin),
    .equalizer_off_input(eqOff), .standAloneIn(alone), .eq_settled_flag(lock),
    .colorForced(cForced), .polForced(pForced));
  eqs_board_model board (.colorOut(colorOut), .colorOe(colorOe), .colorDrv(colorDrv),
    .colorVal(colorVal), .polOut(polOut), .polOe(polOe), .polDrv(polDrv), .polVal(polVal),
    .lockIn(lock), .lockToFreeze(lockToFreeze), .freezeReq(freezeReq),
    .colorPin(colorPin), .polPin(polPin), .freezePin(freezePin));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic waitLock();
    for (int i = 0; i < SETTLE + 20 && lock !== 1'h1; i++)
      cyc(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_force();
    det = '{1'h1, 1'h1, 1'h1, 1'h0};
    cyc(5);
    chk(colorOut, 1'h1);
    chk(polOut, 1'h1);
    chk(ctrl.colorMode, 1'h1);
    chk(cForced, 1'h0);
    colorDrv = 1'h1;
    polDrv = 1'h1;
    cyc(5);
    chk(ctrl.colorMode, 1'h0);
    chk(ctrl.invertChain, 1'h0);
    chk(cForced, 1'h1);
    chk(pForced, 1'h1);
    det = '{1'h1, 1'h0, 1'h0, 1'h0};
    colorVal = 1'h1;
    polVal = 1'h1;
    cyc(5);
    chk(colorOut, 1'h0);
    chk(polOut, 1'h0);
    chk(ctrl.colorMode, 1'h1);
    chk(ctrl.invertChain, 1'h1);
    colorDrv = 1'h0;
    polDrv = 1'h0;
    $display("force test done");
  endtask
  task automatic t_lock();
    det = '{1'h1, 1'h0, 1'h0, 1'h1};
    waitLock();
    chk(lock, 1'h1);
    det.signalPresent = 1'h0;
    cyc(2);
    chk(lock, 1'h0);
    det.signalPresent = 1'h1;
    waitLock();
    $display("lock test done");
  endtask
  task automatic t_freeze();
    bit seen;
    seen = 1'h0;
    cyc(1300);
    lockToFreeze = 1'h1;
    cyc(5);
    chk(ctrl.eqUpdateEn, 1'h0);
    det.eqConverged = 1'h0;
    cyc(5);
    chk(lock, 1'h1);
    polVal = 1'h1;
    polDrv = 1'h1;
    cyc(5);
    polVal = 1'h0;
    for (int i = 0; i < 10; i++)
    begin
      cyc(1);
      seen = seen | (ctrl.acqRestart === 1'h1);
    end
    chk(seen, 1'h1);
    chk(lock, 1'h0);
    chk(ctrl.eqUpdateEn, 1'h1);
    polDrv = 1'h0;
    lockToFreeze = 1'h0;
    $display("freeze test done");
  endtask
  task automatic t_eqoff();
    det.eqConverged = 1'h1;
    waitLock();
    eqOff = 1'h1;
    cyc(5);
    chk(ctrl.eqBypass, 1'h1);
    chk(ctrl.eqUpdateEn, 1'h0);
    chk(lock, 1'h0);
    eqOff = 1'h0;
    cyc(5);
    chk(ctrl.eqBypass, 1'h0);
    $display("disable test done");
  endtask
  // freeze driven straight from the strap, then a polarity pulse while not stand-alone
  task automatic t_alone();
    bit seen;
    seen = 1'h0;
    alone = 1'h0;
    freezeReq = 1'h1;
    cyc(5);
    chk(ctrl.eqUpdateEn, 1'h0);
    freezeReq = 1'h0;
    polVal = 1'h1;
    polDrv = 1'h1;
    cyc(5);
    chk(pForced, 1'h1);
    chk(cForced, 1'h0);
    chk(ctrl.eqUpdateEn, 1'h1);
    polVal = 1'h0;
    for (int i = 0; i < 10; i++)
    begin
      cyc(1);
      seen = seen | (ctrl.acqRestart === 1'h1);
    end
    chk(seen, 1'h0);
    polDrv = 1'h0;
    alone = 1'h1;
    $display("stand-alone test done");
  endtask
  initial
  begin
    {rst_n, colorDrv, colorVal, polDrv, polVal, lockToFreeze, freezeReq, eqOff} = 8'h00;
    alone = 1'h1;
    det = '0;
    mismatches = 0;
    samplesChecked = 0;
    cyc(16);
    rst_n = 1'h1;
    cyc(2);
    t_force();
    t_lock();
    t_freeze();
    t_eqoff();
    t_alone();
    end_of_test();
  end
  initial
  begin
    #50000;
    mismatches++;
    end_of_test();
  end
endmodule
bind eqs_status_pins eqs_status_pins_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);
